// ---- rtl/rtcr_regs.sv ----
/*
  Time, calendar and alarm registers with BCD timekeeping and alarm flag.
  Assumes a one-second pulse from the clock source and a register port
  whose requests are synchronous to clk_sys_in.
*/
// Notes on behaviour
// RULE1: Seconds: tens 6:4 up to 5, units 3:0 up to 9, bit 7 zero.
// RULE2: Minutes: tens 6:4 up to 5, units 3:0 up to 9, bit 7 zero.
// RULE3: Hours: tens 5:4 up to 2, units 3:0, bit 6 reads zero.
// RULE4: Hours bit 7 is afternoon in twelve-hour mode, else zero.
// RULE5: Day: tens 5:4 up to 3, units 3:0, units reset to one.
// RULE6: Month: tens bit 4, units 3:0 reset to one, bits 7:5 zero.
// RULE7: Year: two BCD digits 7:4 and 3:0, reset to zero.
// RULE8: Weekday code 0 to 6 in bits 2:0, upper bits zero.
// RULE9: Alarm seconds: BCD tens 6:4 up to 5, units 3:0.
// RULE10: Alarm minutes: BCD tens 6:4 up to 5, units 3:0.
// RULE11: Alarm hours: tens 5:4 up to 2, units 3:0, bit 6 reserved.
// RULE12: Alarm hours bit 7 is afternoon in twelve-hour mode only.
// RULE13: Alarm day: tens 5:4 up to 3, units reset to one.
// RULE14: Only full reset initialises; zero except day/month units one.
// RULE15: Format bit picks 24 or 12 hour; switching keeps time intact.
// RULE16: Running clock counts seconds with BCD carries and weekday.
// RULE17: Time matching alarm fields raises an alarm flag.
// RULE18: Reserved bits ignore writes and read zero.
`timescale 1ns/100ps
module rtcr_regs
  import rtcr_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       arst_n_in,
  input  wire logic       tick_1hz_in,
  input  wire logic       run_in,
  input  wire logic       twelve_hour_format_in,
  input  wire rtcr_req_t  req_in,
  input  wire logic       alarm_clear_in,
  output logic [7:0]      reg_rdata_out,
  output logic            reg_rvalid_out,
  output logic            alarm_flag_out
);

  // ==========================================================
  // Reset release
  logic [1:0]  rst_sync;
  logic        rst_n;
  rtcr_state_t q;
  rtcr_state_t next_q;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_sync <= 2'b00;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ==========================================================
  // Conversion helpers
  function automatic logic [6:0] b2n(input logic [7:0] b);
    b2n = 7'(({3'b000, b[7:4]} * 7'd10) + {3'b000, b[3:0]});
  endfunction : b2n

  function automatic logic [7:0] n2b(input logic [6:0] n);
    logic [6:0] t;
    logic [6:0] u;
    t = n / 7'd10;
    u = 7'(n - 7'(t * 7'd10));
    n2b = {t[3:0], u[3:0]};
  endfunction : n2b

  function automatic logic dig_ok(input logic [7:0] b, input logic [3:0] tmax);
    dig_ok = (b[3:0] <= 4'h9) && (b[7:4] <= tmax);
  endfunction : dig_ok

  // Days of a month; years are 2000..2099 so every fourth is leap
  function automatic logic [6:0] mdays(input logic [7:0] m, input logic [7:0] y);
    logic [6:0] yn;
    yn = b2n(y);
    case (b2n(m))
      7'd2: mdays = (yn[1:0] == 2'b00) ? 7'd29 : 7'd28;
      7'd4, 7'd6, 7'd9, 7'd11: mdays = 7'd30;
      default: mdays = 7'd31;
    endcase
  endfunction : mdays

  // Stored 24-hour value shown in the current format
  function automatic logic [7:0] hour_rd(input logic [7:0] h, input logic tw);
    logic [6:0] n;
    logic [7:0] b;
    logic       pm;
    n = b2n(h);
    pm = 1'b0;
    if (n >= 7'd12)
    begin
      pm = 1'b1;
      n = 7'(n - 7'd12);
    end
    if (n == 7'd0)
    begin
      n = 7'd12;
    end
    b = n2b(n);
    hour_rd = tw ? {pm, 1'b0, b[5:0]} : {2'b00, h[5:0]}; // RULE4 RULE12 RULE15
  endfunction : hour_rd

  // Written value in the current format; bit 8 flags a legal hour
  function automatic logic [8:0] hour_wr(input logic [7:0] w, input logic tw);
    logic [6:0] n;
    logic [7:0] b;
    logic       ok;
    n = b2n({2'b00, w[5:0]});
    ok = dig_ok({2'b00, w[5:0]}, TENS_MAX_H);
    if (tw)
    begin
      ok = ok && (n >= 7'd1) && (n <= 7'd12);
      if (n == 7'd12)
      begin
        n = 7'd0;
      end
      if (w[PM_BIT])
      begin
        n = 7'(n + 7'd12);
      end
    end
    else
    begin
      ok = ok && (n <= 7'd23);
    end
    b = n2b(n);
    hour_wr = {ok, 2'b00, b[5:0]};
  endfunction : hour_wr

  // ==========================================================
  // Next-state logic: timekeeping, alarm, register access
  always_comb
  begin
    logic [6:0] s;
    logic [6:0] m;
    logic [6:0] h;
    logic [6:0] d;
    logic [6:0] mo;
    logic [6:0] y;
    logic [8:0] hw;
    logic [7:0] wd;
    logic       match;
    s = b2n(q.sec);
    m = b2n(q.min);
    h = b2n(q.hour);
    d = b2n(q.day);
    mo = b2n(q.mon);
    y = b2n(q.year);
    wd = req_in.wdata;
    match = 1'b0;
    hw = hour_wr(wd, twelve_hour_format_in);
    next_q = q;
    next_q.rvalid = req_in.rd;
    // Advance one second with carries
    if (run_in && tick_1hz_in) // RULE16
    begin
      s = 7'(s + 7'd1);
      if (s == 7'd60)
      begin
        s = 7'd0;
        m = 7'(m + 7'd1);
        if (m == 7'd60)
        begin
          m = 7'd0;
          h = 7'(h + 7'd1);
          if (h == 7'd24)
          begin
            h = 7'd0;
            next_q.week = (q.week >= WEEK_MAX) ? 3'h0 : 3'(q.week + 3'h1);
            if (d >= mdays(q.mon, q.year))
            begin
              d = 7'd1;
              mo = 7'(mo + 7'd1);
              if (mo == 7'd13)
              begin
                mo = 7'd1;
                y = (y == 7'd99) ? 7'd0 : 7'(y + 7'd1);
              end
            end
            else
            begin
              d = 7'(d + 7'd1);
            end
          end
        end
      end
      next_q.sec = n2b(s);
      next_q.min = n2b(m);
      next_q.hour = n2b(h);
      next_q.day = n2b(d);
      next_q.mon = n2b(mo);
      next_q.year = n2b(y);
    end
    // Writes override counting; illegal digits leave the register alone
    if (req_in.wr)
    begin
      if (req_in.addr == OFS_SEC)
      begin
        if (dig_ok({1'b0, wd[6:0]}, TENS_MAX_S)) next_q.sec = {1'b0, wd[6:0]}; // RULE1
      end
      else if (req_in.addr == OFS_MIN)
      begin
        if (dig_ok({1'b0, wd[6:0]}, TENS_MAX_S)) next_q.min = {1'b0, wd[6:0]}; // RULE2
      end
      else if (req_in.addr == OFS_HOUR)
      begin
        if (hw[8]) next_q.hour = hw[7:0]; // RULE3 RULE4 RULE15
      end
      else if (req_in.addr == OFS_DAY)
      begin
        if (dig_ok({2'b00, wd[5:0]}, TENS_MAX_D) && wd[5:0] != 6'h00)
          next_q.day = {2'b00, wd[5:0]}; // RULE5
      end
      else if (req_in.addr == OFS_MON)
      begin
        if (dig_ok({3'b000, wd[4:0]}, TENS_MAX_M) && b2n({3'b000, wd[4:0]}) >= 7'd1
            && b2n({3'b000, wd[4:0]}) <= 7'd12)
          next_q.mon = {3'b000, wd[4:0]}; // RULE6
      end
      else if (req_in.addr == OFS_YEAR)
      begin
        if (dig_ok(wd, TENS_MAX_Y)) next_q.year = wd; // RULE7
      end
      else if (req_in.addr == OFS_WEEK)
      begin
        if (wd[2:0] <= WEEK_MAX) next_q.week = wd[2:0]; // RULE8 RULE18
      end
      else if (req_in.addr == OFS_ASEC)
      begin
        if (dig_ok({1'b0, wd[6:0]}, TENS_MAX_S)) next_q.asec = {1'b0, wd[6:0]}; // RULE9
      end
      else if (req_in.addr == OFS_AMIN)
      begin
        if (dig_ok({1'b0, wd[6:0]}, TENS_MAX_S)) next_q.amin = {1'b0, wd[6:0]}; // RULE10
      end
      else if (req_in.addr == OFS_AHOUR)
      begin
        if (hw[8]) next_q.ahour = hw[7:0]; // RULE11 RULE12
      end
      else if (req_in.addr == OFS_ADAY)
      begin
        if (dig_ok({2'b00, wd[5:0]}, TENS_MAX_D) && wd[5:0] != 6'h00)
          next_q.aday = {2'b00, wd[5:0]}; // RULE13
      end
    end
    // Read data; reserved bits and holes read zero
    next_q.rdata = q.rdata;
    if (req_in.rd)
    begin
      if (req_in.addr == OFS_SEC) next_q.rdata = q.sec; // RULE18
      else if (req_in.addr == OFS_MIN) next_q.rdata = q.min;
      else if (req_in.addr == OFS_HOUR) next_q.rdata = hour_rd(q.hour, twelve_hour_format_in);
      else if (req_in.addr == OFS_DAY) next_q.rdata = q.day;
      else if (req_in.addr == OFS_MON) next_q.rdata = q.mon;
      else if (req_in.addr == OFS_YEAR) next_q.rdata = q.year;
      else if (req_in.addr == OFS_WEEK) next_q.rdata = {5'h00, q.week};
      else if (req_in.addr == OFS_ASEC) next_q.rdata = q.asec;
      else if (req_in.addr == OFS_AMIN) next_q.rdata = q.amin;
      else if (req_in.addr == OFS_AHOUR) next_q.rdata = hour_rd(q.ahour, twelve_hour_format_in);
      else if (req_in.addr == OFS_ADAY) next_q.rdata = q.aday;
      else next_q.rdata = RST_ZERO;
    end
    // Alarm flag: a new match sets, clear drops, set wins
    match = (q.sec == q.asec) && (q.min == q.amin) && (q.hour == q.ahour)
            && (q.day == q.aday);
    next_q.match_d = match;
    if (alarm_clear_in) next_q.alarm = 1'b0;
    if (match && !q.match_d) next_q.alarm = 1'b1; // RULE17
  end

  // State register, full reset only
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= STATE_RST; // RULE14
    end
    else
    begin
      q <= next_q;
    end
  end

  assign reg_rdata_out = q.rdata;
  assign reg_rvalid_out = q.rvalid;
  assign alarm_flag_out = q.alarm;

  // ==========================================================
  // Checks
  a_sec_range: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    q.sec[7] == 1'b0 && q.sec[6:4] <= 3'h5 && q.sec[3:0] <= 4'h9) // RULE1
    else $error("seconds out of range");
  a_min_range: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    q.min[7] == 1'b0 && q.min[6:4] <= 3'h5 && q.min[3:0] <= 4'h9) // RULE2
    else $error("minutes out of range");
  a_hour_range: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    q.hour[7:6] == 2'b00 && b2n(q.hour) <= 7'd23) // RULE3
    else $error("hours out of range");
  a_pm_24h: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    req_in.rd && req_in.addr == OFS_HOUR && !twelve_hour_format_in
    |=> reg_rvalid_out && reg_rdata_out[7:6] == 2'b00) // RULE4
    else $error("afternoon bit set in 24-hour mode");
  a_cal_range: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    q.day[7:4] <= 4'h3 && q.day[3:0] <= 4'h9 && q.day[5:0] != 6'h00
    && b2n(q.mon) >= 7'd1 && b2n(q.mon) <= 7'd12) // RULE5
    else $error("day or month out of range");
  a_week_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    req_in.rd && req_in.addr == OFS_WEEK
    |=> reg_rdata_out[7:3] == 5'h00 && reg_rdata_out[2:0] <= 3'h6) // RULE8
    else $error("weekday read wrong");
  a_sec_tick: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    rst_n && run_in && tick_1hz_in && !req_in.wr && q.sec[3:0] < 4'h9
    |=> q.sec[3:0] == $past(q.sec[3:0]) + 4'h1) // RULE16
    else $error("seconds did not advance");
  a_alarm_set: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    rst_n && q.sec == q.asec && q.min == q.amin && q.hour == q.ahour && q.day == q.aday
    && !q.match_d |=> alarm_flag_out) // RULE17
    else $error("alarm flag not raised");
  a_hole_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    req_in.rd && req_in.addr == 8'h07 |=> reg_rdata_out == 8'h00) // RULE18
    else $error("unmapped offset not zero");

endmodule : rtcr_regs

// ---- rtl/rtcr_pkg.sv ----
/*
  Shared constants and types of the clock/calendar/alarm register block.
  Assumes an 8-bit register port driven by the serial control decoder.
*/
package rtcr_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_SEC   = 8'h00;
  localparam logic [7:0] OFS_MIN   = 8'h01;
  localparam logic [7:0] OFS_HOUR  = 8'h02;
  localparam logic [7:0] OFS_DAY   = 8'h03;
  localparam logic [7:0] OFS_MON   = 8'h04;
  localparam logic [7:0] OFS_YEAR  = 8'h05;
  localparam logic [7:0] OFS_WEEK  = 8'h06;
  localparam logic [7:0] OFS_ASEC  = 8'h08;
  localparam logic [7:0] OFS_AMIN  = 8'h09;
  localparam logic [7:0] OFS_AHOUR = 8'h0a;
  localparam logic [7:0] OFS_ADAY  = 8'h0b;

  // ==========================================================
  // Field positions and tens-digit limits
  localparam int         PM_BIT     = 7;
  localparam logic [3:0] TENS_MAX_S = 4'h5;
  localparam logic [3:0] TENS_MAX_H = 4'h2;
  localparam logic [3:0] TENS_MAX_D = 4'h3;
  localparam logic [3:0] TENS_MAX_M = 4'h1;
  localparam logic [3:0] TENS_MAX_Y = 4'h9;
  localparam logic [2:0] WEEK_MAX   = 3'h6;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONE  = 8'h01;

  // Register port request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtcr_req_t;

  // Whole state of the block; hours are kept in 24-hour BCD
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] mon;
    logic [7:0] year;
    logic [2:0] week;
    logic [7:0] asec;
    logic [7:0] amin;
    logic [7:0] ahour;
    logic [7:0] aday;
    logic       match_d;
    logic       alarm;
    logic       rvalid;
    logic [7:0] rdata;
  } rtcr_state_t;

  localparam rtcr_state_t STATE_RST = '{
    sec: RST_ZERO, min: RST_ZERO, hour: RST_ZERO, day: RST_ONE,
    mon: RST_ONE, year: RST_ZERO, week: 3'h0, asec: RST_ZERO,
    amin: RST_ZERO, ahour: RST_ZERO, aday: RST_ONE, match_d: 1'b0,
    alarm: 1'b0, rvalid: 1'b0, rdata: RST_ZERO};

endpackage : rtcr_pkg

// ---- test/rtcr_host_model.sv ----
/*
  Host model that issues single-byte register reads and writes.
  Assumes requests are taken on a rising edge of clk_sys_in.
*/
`timescale 1ns/100ps
module rtcr_host_model
  import rtcr_pkg::*;
(
  input  wire logic clk_sys_in,
  output rtcr_req_t req_out
);
  // ==========================================================
  // Idle bus at start
  initial req_out = '0;

  // One strobe for one edge, then release and idle for gap cycles
  task automatic access(input logic is_wr, input logic [7:0] addr,
                        input logic [7:0] data, input int gap);
    @(posedge clk_sys_in);
    #1;
    req_out = '{rd: !is_wr, wr: is_wr, addr: addr, wdata: data};
    @(posedge clk_sys_in);
    #1;
    // Released lines show the inverse so stale values never match
    req_out = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
    repeat (gap) @(posedge clk_sys_in);
  endtask : access
endmodule : rtcr_host_model

// ---- test/tb_top.sv ----
/*
  Self-checking bench of the clock/calendar/alarm registers.
  Assumes the host model drives the register port; the bench drives the rest.
*/
`timescale 1ns/100ps
module tb_top
  import rtcr_pkg::*;
;
  // ==========================================================
  // Signals and bookkeeping
  logic        clk_sys_in, arst_n_in, tick_1hz_in, run_in;
  logic        twelve_hour_format_in, alarm_clear_in;
  rtcr_req_t   req;
  logic [7:0]  rdata;
  logic        rvalid, alarm_flag;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h0000_0019;
  logic [7:0]  val;
  int          n_fail, total_checks, cycles;
  logic [7:0]  ofs_t[11] = '{OFS_SEC, OFS_MIN, OFS_HOUR, OFS_DAY, OFS_MON, OFS_YEAR,
                             OFS_WEEK, OFS_ASEC, OFS_AMIN, OFS_AHOUR, OFS_ADAY};
  logic [7:0]  rst_t[11] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00,
                             8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
  logic [7:0]  good_t[11] = '{8'h59, 8'h58, 8'h23, 8'h31, 8'h12, 8'h99,
                              8'h06, 8'h30, 8'h15, 8'h07, 8'h28};
  logic [7:0]  bad_t[11] = '{8'h5a, 8'h60, 8'h24, 8'h00, 8'h13, 8'h9a,
                             8'h07, 8'h70, 8'h0a, 8'h30, 8'h40};

  rtcr_host_model host (.clk_sys_in(clk_sys_in), .req_out(req));

  rtcr_regs dut (
    .clk_sys_in           (clk_sys_in),
    .arst_n_in            (arst_n_in),
    .tick_1hz_in          (tick_1hz_in),
    .run_in               (run_in),
    .twelve_hour_format_in(twelve_hour_format_in),
    .req_in               (req),
    .alarm_clear_in       (alarm_clear_in),
    .reg_rdata_out        (rdata),
    .reg_rvalid_out       (rvalid),
    .alarm_flag_out       (alarm_flag)
  );

  // ==========================================================
  // Clock and hang guard
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_fail++;
      $display("Error run length: expected end before 4000 cycles, seen hang");
      final_report();
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    seed = xs(seed);
    host.access(1'b1, a, d, int'(seed[1:0]));
  endtask : wr

  // Notes the expected value, then issues the read
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({a, e});
    seed = xs(seed);
    host.access(1'b0, a, 8'h00, int'(seed[1:0]));
  endtask : rd

  task automatic pulse(ref logic s);
    @(posedge clk_sys_in);
    #1 s = 1'b1;
    @(posedge clk_sys_in);
    #1 s = 1'b0;
  endtask : pulse

  task automatic check_read(input logic [15:0] note);
    total_checks++;
    if (rdata !== note[7:0])
    begin
      n_fail++;
      $display("Error reg 0x%h: expected 0x%h seen 0x%h", note[15:8], note[7:0], rdata);
    end
  endtask : check_read

  task automatic check_flag(input logic e);
    repeat (2) @(posedge clk_sys_in);
    #1 total_checks++;
    if (alarm_flag !== e)
    begin
      n_fail++;
      $display("Error alarm flag: expected %b seen %b", e, alarm_flag);
    end
  endtask : check_flag

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // Takes the oldest note whenever read data appears
  always @(posedge clk_sys_in)
  begin
    if (rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check_read(16'hffff);
      else
        check_read(exp_q.pop_front());
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    {arst_n_in, tick_1hz_in, run_in, twelve_hour_format_in, alarm_clear_in} = '0;
    repeat (5) @(posedge clk_sys_in);
    #1 arst_n_in = 1'b1;
    // State leaves reset only at the second edge, the flag one edge later
    @(posedge clk_sys_in);
    check_flag(1'b1);
    // Reset values and unmapped places
    for (int i = 0; i < 11; i++) rd(ofs_t[i], rst_t[i]);
    wr(8'h07, 8'hff);
    rd(8'h07, 8'h00);
    rd(8'h0c, 8'h00);
    // Good value kept, out-of-range value refused
    for (int i = 0; i < 11; i++)
    begin
      wr(ofs_t[i], good_t[i]);
      wr(ofs_t[i], bad_t[i]);
      rd(ofs_t[i], good_t[i]);
    end
    repeat (4)
    begin
      seed = xs(seed);
      val = {seed[3:0] % 4'h6, seed[11:8] % 4'ha};
      wr(OFS_MIN, val);
      rd(OFS_MIN, val);
    end
    // Hour format switching changes only the view
    wr(OFS_HOUR, 8'h13);
    @(posedge clk_sys_in) #1 twelve_hour_format_in = 1'b1;
    rd(OFS_HOUR, 8'h81);
    wr(OFS_HOUR, 8'h12);
    wr(OFS_AHOUR, 8'h92);
    rd(OFS_AHOUR, 8'h92);
    @(posedge clk_sys_in) #1 twelve_hour_format_in = 1'b0;
    rd(OFS_HOUR, 8'h00);
    rd(OFS_AHOUR, 8'h12);
    // Full rollover at the last second of a century
    for (int i = 0; i < 7; i++) wr(ofs_t[i], good_t[i]);
    wr(OFS_MIN, 8'h59);
    pulse(tick_1hz_in);
    rd(OFS_SEC, 8'h59);
    @(posedge clk_sys_in) #1 run_in = 1'b1;
    pulse(tick_1hz_in);
    for (int i = 0; i < 7; i++) rd(ofs_t[i], rst_t[i]);
    // Alarm one second ahead
    wr(OFS_ASEC, 8'h01);
    wr(OFS_AMIN, 8'h00);
    wr(OFS_AHOUR, 8'h00);
    wr(OFS_ADAY, 8'h01);
    pulse(alarm_clear_in);
    check_flag(1'b0);
    pulse(tick_1hz_in);
    check_flag(1'b1);
    pulse(alarm_clear_in);
    check_flag(1'b0);
    // Second full reset in mid-run
    repeat (3) @(posedge clk_sys_in);
    #1 arst_n_in = 1'b0;
    repeat (2) @(posedge clk_sys_in);
    #1 arst_n_in = 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rd(OFS_YEAR, 8'h00);
    rd(OFS_DAY, 8'h01);
    repeat (3) @(posedge clk_sys_in);
    if (exp_q.size() != 0)
    begin
      n_fail++;
      $display("Error read queue: expected 0 seen %0d", exp_q.size());
    end
    final_report();
  end
endmodule : tb_top
